// ### core/usc_core.sv
/*
 * Dual-mode serial core: UART or SPI master/slave behind a classic
 * Wishbone register port (ref_clk) with the serial engine on link_clk.
 * Assumes link_clk runs free and configuration changes only while idle.
 */
`timescale 1ns/1ps
`default_nettype none
module usc_core (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire logic                      link_clk,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [usc_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      ser_in,
   output logic                           ser_out,
   input  wire logic                      sclk_in,
   output logic                           sclk_out,
   input  wire logic                      ss_n_in,
   output logic                           ss_n_out
);
   import usc_pkg::*;

   // -----------------------------------------------------------------
   // Register domain (ref_clk)
   // -----------------------------------------------------------------
   logic [7:0] mant, gctl, tx_hold, rx_buf, rd;
   logic [2:0] frame;
   logic       mode, rx_en, slave, ferr, perr, rxrdy, txdone, active;
   logic       tx_tog, tx_pend;
   logic [4:0] ev_q, ev_p;
   logic [3:0] ev;
   logic [7:0] rx_data;

   wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr  = req & wb_we_i & wb_sel_i[0];
   wire [7:0] idx = wb_adr_i[9:2];
   wire       wr_data = wr && idx == IDX_DATA;
   wire       wr_csr  = wr && idx == IDX_CSR;
   // Event edges from the link side: tx, rx, framing, parity
   assign ev = ev_q[3:0] ^ ev_p[3:0];

   // Answer every request one cycle later, unmapped ones included
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Read mux; unmapped indices read as zero
   always_comb begin
      if (idx == IDX_DATA) begin
         rd = rx_buf;
      end else if (idx == IDX_MANT) begin
         rd = mant;
      end else if (idx == IDX_GCTL) begin
         rd = gctl;
      end else if (idx == IDX_FRAME) begin
         rd = {5'h00, frame};
      end else if (idx == IDX_CSR) begin
         rd = {mode, rx_en, slave, ferr, perr, rxrdy, txdone, active};
      end else begin
         rd = 8'h00;
      end
   end

   // Read data is registered with the acknowledge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= {24'h000000, rd};
      end
   end

   // Configuration registers
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mant  <= MANT_RST;
         gctl  <= GCTL_RST;
         frame <= FRAME_RST;
         mode  <= 1'b0;
         rx_en <= 1'b0;
         slave <= 1'b0;
      end else if (wr) begin
         if (idx == IDX_MANT) begin
            mant <= wb_dat_i[7:0];
         end else if (idx == IDX_GCTL) begin
            gctl <= wb_dat_i[7:0];
         end else if (idx == IDX_FRAME) begin
            frame <= wb_dat_i[2:0];
         end else if (idx == IDX_CSR) begin
            mode  <= wb_dat_i[CSR_MODE];
            rx_en <= wb_dat_i[CSR_RXEN];
            slave <= wb_dat_i[CSR_SLAVE];
         end
      end
   end

   // Transmit hand-off: byte held still while the toggle crosses
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_hold <= DATA_RST;
         tx_tog  <= 1'b0;
         tx_pend <= 1'b0;
      end else begin
         if (wr_data) begin
            tx_hold <= wb_dat_i[7:0];
            tx_tog  <= ~tx_tog;
         end
         tx_pend <= wr_data | (tx_pend & ~ev[0]);
      end
   end

   // Sticky flags: hardware set beats a software clear
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         txdone <= 1'b0;
         rxrdy  <= 1'b0;
         ferr   <= 1'b0;
         perr   <= 1'b0;
         active <= 1'b0;
         rx_buf <= DATA_RST;
         ev_p   <= 5'h00;
      end else begin
         ev_p   <= ev_q;
         txdone <= ev[0] | (wr_csr ? wb_dat_i[CSR_TXDONE] : txdone);
         rxrdy  <= ev[1] | (wr_csr ? wb_dat_i[CSR_RXRDY] : rxrdy);
         ferr   <= ev[2] | (wr_csr ? wb_dat_i[CSR_FERR] : ferr);
         perr   <= ev[3] | (wr_csr ? wb_dat_i[CSR_PERR] : perr);
         active <= ev_q[4] | tx_pend | wr_data;
         if (ev[1]) begin
            rx_buf <= rx_data;
         end
      end
   end

   // -----------------------------------------------------------------
   // Domain crossings
   // -----------------------------------------------------------------
   logic       l_rst_n;
   logic [22:0] l_cfg;
   logic [2:0] l_pin;
   logic       tx_t, rx_t, ferr_t, pe_t, l_active;

   // Link reset asserts at once and releases on link_clk
   usc_sync #(.WIDTH(1)) u_rst_sync (
      .clk   (link_clk),
      .rst_n (reset_n),
      .d     (1'b1),
      .q     (l_rst_n)
   );

   // Quasi-static configuration plus the transmit toggle
   usc_sync #(.WIDTH(23)) u_cfg_sync (
      .clk   (link_clk),
      .rst_n (l_rst_n),
      .d     ({tx_tog, mode, slave, rx_en, gctl, mant, frame}),
      .q     (l_cfg)
   );

   // Serial input pins
   usc_sync #(.WIDTH(3)) u_pin_sync (
      .clk   (link_clk),
      .rst_n (l_rst_n),
      .d     ({ser_in, sclk_in, ss_n_in}),
      .q     (l_pin)
   );

   // Event toggles and busy level back to the register side
   usc_sync #(.WIDTH(5)) u_ev_sync (
      .clk   (ref_clk),
      .rst_n (reset_n),
      .d     ({l_active, pe_t, ferr_t, rx_t, tx_t}),
      .q     (ev_q)
   );

   // -----------------------------------------------------------------
   // Serial engine (link_clk)
   // -----------------------------------------------------------------
   wire       l_tog   = l_cfg[22];
   wire       l_mode  = l_cfg[21];
   wire       l_slave = l_cfg[20];
   wire       l_rxen  = l_cfg[19];
   // Control byte sits at bits 18:11 of the crossed bundle
   wire       l_idle  = l_cfg[11 + GCTL_IDLE];
   wire       l_cpha  = l_cfg[11 + GCTL_CPHA];
   wire       l_order = l_cfg[11 + GCTL_ORDER];
   wire [4:0] l_exp   = l_cfg[15:11];
   wire [7:0] l_mant  = l_cfg[10:3];
   wire       l_pe    = l_cfg[FRM_PEN];
   wire       l_podd  = l_cfg[FRM_PODD];
   wire       l_two   = l_cfg[FRM_TWO];
   wire       l_rx    = l_pin[2];
   wire       l_sclk  = l_pin[1];
   wire       l_ss_n  = l_pin[0];

   usc_state_t        st;
   logic [RATE_W-1:0] cnt, period, tgt;
   logic [3:0]        bidx, flen, stop1;
   logic [4:0]        ecnt;
   logic [7:0]        txsh, rxsh, rx_next, d_ord;
   logic [11:0]       fr, uframe;
   logic              pacc, req_pend, l_tog_p, l_sclk_p;
   logic              lead, trail, m_edge;

   function automatic logic [7:0] ins(input logic [7:0] s,
                                      input logic b, input logic msb);
      ins = msb ? {s[6:0], b} : {b, s[7:1]};
   endfunction

   // Bit time in link cycles: (mantissa + 1) shifted by the exponent
   assign period = (RATE_W'(l_mant) + RATE_W'(1)) << l_exp;
   assign stop1  = STOP1_IDX + {3'h0, l_pe};
   assign flen   = 4'hA + {3'h0, l_pe} + {3'h0, l_two};

   // Frame, edge and sample helpers
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         d_ord[i] = l_order ? tx_hold[7 - i] : tx_hold[i];
      end
      uframe  = {UART_STOP, UART_STOP,
                 l_pe ? (^tx_hold ^ l_podd) : UART_STOP, d_ord, UART_START};
      tgt     = (bidx == 4'h0) ? (period >> 1) : period - RATE_W'(1);
      m_edge  = !l_slave && cnt == period - RATE_W'(1);
      lead    = st == ST_SPI && (l_slave ?
                (l_sclk_p == l_idle && l_sclk != l_idle) :
                (m_edge && sclk_out == l_idle));
      trail   = st == ST_SPI && (l_slave ?
                (l_sclk_p != l_idle && l_sclk == l_idle) :
                (m_edge && sclk_out != l_idle));
      rx_next = ((l_cpha ? trail : lead)) ? ins(rxsh, l_rx, l_order) : rxsh;
   end

   // History of crossed toggles and pins, busy level
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_tog_p  <= 1'b0;
         l_sclk_p <= 1'b0;
         l_active <= 1'b0;
      end else begin
         l_tog_p  <= l_tog;
         l_sclk_p <= l_sclk;
         l_active <= st != ST_IDLE;
      end
   end

   // Engine sequencer; the master's miso sample lags two link cycles
   always_ff @(posedge link_clk or negedge l_rst_n) begin
      if (!l_rst_n) begin
         st <= ST_IDLE;
         cnt <= '0;
         bidx <= 4'h0;
         ecnt <= 5'h00;
         txsh <= 8'h00;
         rxsh <= 8'h00;
         fr <= 12'hFFF;
         pacc <= 1'b0;
         rx_data <= DATA_RST;
         req_pend <= 1'b0;
         {tx_t, rx_t, ferr_t, pe_t} <= 4'h0;
         ser_out <= 1'b1;
         sclk_out <= 1'b0;
         ss_n_out <= 1'b1;
      end else begin
         req_pend <= req_pend | (l_tog ^ l_tog_p);
         case (st)
            ST_IDLE: begin
               cnt <= '0;
               bidx <= 4'h0;
               ecnt <= 5'h00;
               sclk_out <= l_idle;
               ss_n_out <= 1'b1;
               ser_out <= 1'b1;
               if (l_mode && req_pend) begin
                  st <= ST_UTX;
                  fr <= uframe;
                  req_pend <= 1'b0;
               end else if (l_mode && l_rxen && l_rx == UART_START) begin
                  st <= ST_URX;
               end else if (!l_mode &&
                            (l_slave ? !l_ss_n : req_pend)) begin
                  st <= ST_SPI;
                  txsh <= tx_hold;
                  ser_out <= l_order ? tx_hold[7] : tx_hold[0];
                  ss_n_out <= l_slave;
                  req_pend <= 1'b0;
               end
            end
            ST_UTX: begin
               ser_out <= fr[0];
               if (cnt == period - RATE_W'(1)) begin
                  cnt <= '0;
                  fr <= {UART_STOP, fr[11:1]};
                  bidx <= bidx + 4'h1;
                  if (bidx == flen - 4'h1) begin
                     st <= ST_IDLE;
                     tx_t <= ~tx_t;
                  end
               end else begin
                  cnt <= cnt + RATE_W'(1);
               end
            end
            ST_URX: begin
               if (cnt == tgt) begin
                  cnt <= '0;
                  bidx <= bidx + 4'h1;
                  if (bidx == 4'h0) begin
                     pacc <= l_podd;
                     if (l_rx != UART_START) begin
                        st <= ST_IDLE; // Glitch, not a start bit
                     end
                  end else if (bidx < STOP1_IDX) begin
                     rxsh <= ins(rxsh, l_rx, l_order);
                     pacc <= pacc ^ l_rx;
                  end else if (bidx < stop1) begin
                     if (pacc ^ l_rx) begin
                        pe_t <= ~pe_t;
                     end
                  end else if (bidx == stop1) begin
                     rx_data <= rxsh;
                     rx_t <= ~rx_t;
                     if (l_rx != UART_STOP) begin
                        ferr_t <= ~ferr_t;
                     end
                     if (!l_two) begin
                        st <= ST_IDLE;
                     end
                  end else begin
                     if (l_rx != UART_STOP) begin
                        ferr_t <= ~ferr_t;
                     end
                     st <= ST_IDLE;
                  end
               end else begin
                  cnt <= cnt + RATE_W'(1);
               end
            end
            ST_SPI: begin
               cnt <= m_edge ? '0 : cnt + RATE_W'(1);
               rxsh <= rx_next;
               if (m_edge) begin
                  sclk_out <= ~sclk_out;
               end
               if (lead | trail) begin
                  ecnt <= ecnt + 5'h01;
               end
               if (lead && l_cpha) begin
                  ser_out <= l_order ? txsh[7] : txsh[0];
                  txsh <= l_order ? {txsh[6:0], 1'b0} : {1'b0, txsh[7:1]};
               end else if (trail && !l_cpha && ecnt != SPI_LAST) begin
                  ser_out <= l_order ? txsh[6] : txsh[1];
                  txsh <= l_order ? {txsh[6:0], 1'b0} : {1'b0, txsh[7:1]};
               end
               if (trail && ecnt == SPI_LAST) begin
                  st <= ST_IDLE;
                  rx_data <= rx_next;
                  rx_t <= ~rx_t;
                  tx_t <= ~tx_t;
               end else if (l_slave && l_ss_n) begin
                  st <= ST_IDLE; // Deselected mid-byte: drop it
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   ack_single_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_timing_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered next cycle");
   tx_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_data |=> tx_hold == $past(wb_dat_i[7:0]) && tx_tog != $past(tx_tog))
      else $error("data write did not load transmit byte");
   rx_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (req && !wb_we_i && idx == IDX_DATA) |=> wb_dat_o[7:0] == $past(rx_buf))
      else $error("data read did not return receive byte");
   rx_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ev[1] |=> rxrdy && rx_buf == $past(rx_data))
      else $error("receive event lost");
   frame_err_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ev[2] |=> ferr)
      else $error("framing event lost");
   parity_err_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ev[3] |=> perr)
      else $error("parity event lost");
   tx_done_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ev[0] |=> txdone && !tx_pend)
      else $error("transmit completion lost");
   flag_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (wr_csr && !wb_dat_i[CSR_FERR] && !ev[2]) |=> !ferr)
      else $error("framing flag not cleared by zero write");
   busy_show_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      wr_data |=> active [*2])
      else $error("active not shown after data write");
   idle_clock_a: assert property (@(posedge link_clk) disable iff (!l_rst_n)
      (st == ST_IDLE && $stable(l_idle)) |=> sclk_out == $past(l_idle))
      else $error("serial clock idle level wrong");
   mode_pick_a: assert property (@(posedge link_clk) disable iff (!l_rst_n)
      (st == ST_IDLE && req_pend && l_mode) |=> st == ST_UTX)
      else $error("uart mode did not start transmit");
endmodule // usc_core
`default_nettype wire

// ### shared/usc_pkg.sv
/*
 * Constants for the dual-mode serial core: register indices, field
 * positions, reset values and the serial engine state type.
 * Assumes a 32-bit Wishbone register port; index N sits at byte 4*N.
 */
`default_nettype none
package usc_pkg;
   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam int unsigned ADR_W     = 10;
   localparam logic [7:0]  IDX_DATA  = 8'hC1;
   localparam logic [7:0]  IDX_MANT  = 8'hC2;
   localparam logic [7:0]  IDX_GCTL  = 8'hC5;
   localparam logic [7:0]  IDX_FRAME = 8'hC6;
   localparam logic [7:0]  IDX_CSR   = 8'hF8;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int unsigned GCTL_IDLE  = 7;
   localparam int unsigned GCTL_CPHA  = 6;
   localparam int unsigned GCTL_ORDER = 5;
   localparam int unsigned CSR_MODE   = 7;
   localparam int unsigned CSR_RXEN   = 6;
   localparam int unsigned CSR_SLAVE  = 5;
   localparam int unsigned CSR_FERR   = 4;
   localparam int unsigned CSR_PERR   = 3;
   localparam int unsigned CSR_RXRDY  = 2;
   localparam int unsigned CSR_TXDONE = 1;
   localparam int unsigned FRM_PEN    = 0;
   localparam int unsigned FRM_PODD   = 1;
   localparam int unsigned FRM_TWO    = 2;
   // ------------------------------------------------------------------
   // Reset values and line levels
   // ------------------------------------------------------------------
   localparam logic [7:0]  DATA_RST   = 8'h00;
   localparam logic [7:0]  MANT_RST   = 8'h00;
   localparam logic [7:0]  GCTL_RST   = 8'h00;
   localparam logic [2:0]  FRAME_RST  = 3'h0;
   localparam logic        UART_START = 1'b0;
   localparam logic        UART_STOP  = 1'b1;
   localparam int unsigned RATE_W     = 40;
   localparam logic [4:0]  SPI_LAST   = 5'h0F;
   localparam logic [3:0]  STOP1_IDX  = 4'h9;

   typedef enum logic [1:0] {ST_IDLE, ST_UTX, ST_URX, ST_SPI} usc_state_t;
endpackage
`default_nettype wire

// ### core/usc_sync.sv
/*
 * Two-flop synchroniser for a bundle of levels or toggles.
 * Assumes each bit is read only through q; bundles are quasi-static.
 */
`timescale 1ns/1ps
`default_nettype none
module usc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   import usc_pkg::*;

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // usc_sync
`default_nettype wire

// ### tb/usc_peer.sv
/*
 * UART peer on the serial pins: sends frames into the core and
 * captures frames the core sends. Assumes an idle-high line and a
 * bit time of P link cycles, matching the rate set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module usc_peer #(
   parameter int P = 8
) (
   input  wire logic link_clk,
   input  wire logic rx_line,
   input  wire logic msb,
   input  wire logic mon,
   output logic      tx_line,
   output logic [7:0] got,
   output int         n_got
);
   logic [7:0] sh;
   initial begin
      tx_line = 1'b1;
      got = 8'h00;
      n_got = 0;
   end
   // ----------------------------------------------------------------
   // Frame sender; stp[1] fills the slot after the first stop bit
   // ----------------------------------------------------------------
   task automatic hold(input logic v);
      @(posedge link_clk);
      tx_line <= v;
      repeat (P - 1) @(posedge link_clk);
   endtask
   task automatic send(input logic [7:0] d, input logic pe,
                       input logic par, input logic [1:0] stp);
      hold(1'b0);
      for (int i = 0; i < 8; i++) hold(msb ? d[7-i] : d[i]);
      if (pe) hold(par);
      hold(stp[0]);
      hold(stp[1]);
      hold(1'b1);
   endtask
   // Capture: sample mid-bit; line idles high so no false starts
   always begin
      @(negedge rx_line);
      if (mon) begin
         repeat (P / 2) @(posedge link_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (P) @(posedge link_clk);
            sh[msb ? 7 - i : i] = rx_line;
         end
         got = sh;
         n_got++;
      end
   end
endmodule // usc_peer
`default_nettype wire

// ### tb/dual_mode_usart_core_tb.sv
/*
 * Self-checking bench for the serial core: registers over Wishbone,
 * UART both ways through the peer, SPI master by loopback.
 * Assumes P=(mantissa+1)<<exponent link cycles per bit.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_mode_usart_core_tb;
   import usc_pkg::*;
   localparam int P = 8;
   logic ref_clk, link_clk, reset_n, cyc, stb, we, msb, mon, spi;
   logic ack, ser_in, ser_out, sclk_out, ss_n_out, ptx, sclk_drv, ss_n_drv;
   logic [ADR_W-1:0] adr;
   logic [31:0]      wdat, dat_o, rd;
   logic [7:0]       got, b;
   int               n_got, n_fail, comparisons, cyc_cnt, k;
   logic [7:0] ids [5] = '{IDX_DATA, IDX_MANT, IDX_GCTL, IDX_CSR, 8'h10};
   // SPI mode loops the core's output back to its input
   assign ser_in = spi ? ser_out : ptx;
   usc_core dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .link_clk(link_clk), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .ser_in(ser_in),
      .ser_out(ser_out), .sclk_in(sclk_drv), .sclk_out(sclk_out),
      .ss_n_in(ss_n_drv), .ss_n_out(ss_n_out));
   usc_peer #(.P(P)) peer (.link_clk(link_clk), .rx_line(ser_out),
      .msb(msb), .mon(mon), .tx_line(ptx), .got(got), .n_got(n_got));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.3;
      forever #7.5 link_clk = ~link_clk;
   end
   // ----------------------------------------------------------------
   // Checks, bus cycles and the closing report
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("fails %0d checks %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Holds the request until ack is sampled high, then releases it
   task automatic wb(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      {cyc, stb, we} <= {2'b11, w};
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask
   // Polls status until a bit sets; bounded number of reads
   task automatic pollb(input int bt);
      k = 0;
      do begin
         wb(1'b0, IDX_CSR, 8'h00);
         k++;
      end while (rd[bt] !== 1'b1 && k < 200);
   endtask
   function automatic logic [7:0] gctl(input logic c, input logic o);
      return {c, c, o, 5'h01};
   endfunction
   always @(posedge ref_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 60000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {cyc, stb, we, msb, mon, spi, reset_n} = 7'h00;
      {sclk_drv, ss_n_drv} = 2'b01;
      adr = '0;
      wdat = 32'h0;
      void'($urandom(62562));
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      foreach (ids[i]) begin
         wb(1'b0, ids[i], 8'h00);
         chk(rd, 32'h0);
      end
      chk(sclk_out, 1'b0);
      wb(1'b1, IDX_MANT, 8'h03);
      wb(1'b0, IDX_MANT, 8'h00);
      chk(rd, 32'h3);
      for (int o = 0; o < 2; o++) begin
         msb = o[0];
         mon = 1'b1;
         wb(1'b1, IDX_GCTL, gctl(1'b0, o[0]));
         wb(1'b1, IDX_CSR, 8'hC0);
         b = $urandom;
         wb(1'b1, IDX_DATA, b);
         repeat (8) @(posedge ref_clk);
         wb(1'b0, IDX_CSR, 8'h00);
         chk(rd[0], 1'b1);
         pollb(CSR_TXDONE);
         // Busy level trails the done flag by the crossing lag
         wb(1'b0, IDX_CSR, 8'h00);
         chk(rd[1:0], 2'b10);
         chk(got, b);
         wb(1'b1, IDX_CSR, 8'hC0);
         wb(1'b0, IDX_CSR, 8'h00);
         chk(rd, 32'hC0);
         b = $urandom;
         peer.send(b, 1'b0, 1'b0, 2'b11);
         pollb(CSR_RXRDY);
         chk(rd[4:2], 3'b001);
         wb(1'b0, IDX_DATA, 8'h00);
         chk(rd, {24'h0, b});
         peer.send(~b, 1'b0, 1'b0, 2'b10);
         pollb(CSR_FERR);
         chk(rd[4], 1'b1);
         wb(1'b1, IDX_FRAME, 8'h05);
         wb(1'b1, IDX_CSR, 8'hC0);
         peer.send(b, 1'b1, ~(^b), 2'b01);
         pollb(CSR_FERR);
         chk(rd[4:2], 3'b111);
         wb(1'b1, IDX_FRAME, 8'h00);
         wb(1'b1, IDX_CSR, 8'h80);
         peer.send(b, 1'b0, 1'b0, 2'b11);
         wb(1'b0, IDX_CSR, 8'h00);
         chk(rd[2], 1'b0);
      end
      mon = 1'b0;
      spi <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         wb(1'b1, IDX_GCTL, gctl(c[0], c[0]));
         wb(1'b1, IDX_CSR, 8'h00);
         repeat (4) @(posedge ref_clk);
         chk(sclk_out, c[0]);
         b = $urandom;
         wb(1'b1, IDX_DATA, b);
         repeat (4) @(posedge ref_clk);
         chk(ss_n_out, 1'b0);
         pollb(CSR_RXRDY);
         wb(1'b0, IDX_DATA, 8'h00);
         chk(rd, {24'h0, b});
         chk({sclk_out, ss_n_out}, {c[0], 1'b1});
      end
      // Slave: bench plays master with a slow clock, output looped back
      wb(1'b1, IDX_GCTL, gctl(1'b0, 1'b0));
      wb(1'b1, IDX_CSR, 8'h20);
      b = $urandom;
      wb(1'b1, IDX_DATA, b);
      ss_n_drv <= 1'b0;
      repeat (4) @(posedge ref_clk);
      repeat (16) begin
         sclk_drv <= ~sclk_drv;
         repeat (2) @(posedge ref_clk);
      end
      ss_n_drv <= 1'b1;
      chk(ss_n_out, 1'b1);
      pollb(CSR_RXRDY);
      wb(1'b0, IDX_DATA, 8'h00);
      chk(rd, {24'h0, b});
      tally_and_finish();
   end
endmodule // dual_mode_usart_core_tb
`default_nettype wire
